//--- rtl/pedp_consts.vh
// Constants shared by the power and energy datapath.
// What this block does
// - Differentiate the voltage sample stream.
// - Integrate differentiated voltage and raw current.
// - Two multipliers: dv times ii, vr times i.
// - Active power is half of p2 minus p1.
// - Quadrature product of integrated voltage and current.
// - Reactive power is quadrature times omega, halved.
// - Reactive power feeds no calibration or pulses.
// - Current RMS from integrated current times omega.
// - Voltage RMS is root mean square per period.
// - Apparent power is product of two RMS values.
// - Active and reactive energy counters wrap up/down; apparent only counts up.
// - Top 20 counter bits form record data.
// - Record upper nibble of top byte holds parity.
`ifndef PEDP_CONSTS_VH
`define PEDP_CONSTS_VH
`define PEDP_SMP_W 16
`define PEDP_ACC_W 32
`define PEDP_REC_W 20
`define PEDP_REC_MSB 27
`define PEDP_PAR_LSB 28
`define PEDP_PERIOD_LOG2 11
`define PEDP_OMEGA_DEF 16'h0100
`define PEDP_OMEGA_SHIFT 8
`endif

//--- rtl/pedp_datapath.v
// Power, RMS and energy datapath of the metering device.
`include "pedp_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module pedp_datapath #(
   parameter W = `PEDP_SMP_W,
   parameter AW = `PEDP_ACC_W,
   parameter LOG2N = `PEDP_PERIOD_LOG2,
   parameter [W-1:0] OMEGA = `PEDP_OMEGA_DEF
) (
   // Clock and reset.
   input wire clk,
   input wire rst_b,
   // Converter sample streams.
   input wire smp_vld,
   input wire signed [W-1:0] v_smp,
   input wire signed [W-1:0] i_smp,
   // Instantaneous powers and apparent power.
   output reg signed [2*W-1:0] p_act_ff,
   output reg signed [2*W-1:0] p_react_ff,
   output reg [2*W-1:0] p_app_ff,
   output reg pwr_vld_ff,
   // RMS values.
   output reg [W-1:0] v_rms_ff,
   output reg [W-1:0] i_rms_ff,
   // Energy data records.
   output reg [31:0] rec_act_ff,
   output reg [31:0] rec_react_ff,
   output reg [31:0] rec_app_ff
);
   // ****************************************
   // Reset synchroniser.
   // ****************************************
   reg rst_s1_ff;
   reg rst_s2_ff;
   wire rst_i_b;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= rst_s1_ff;
      end
   end
   assign rst_i_b = rst_s2_ff;

   // ****************************************
   // Helper functions.
   // ****************************************
   // Scales a product by omega and halves it.
   function signed [2*W-1:0] omega_half;
      input signed [2*W-1:0] x;
      reg signed [3*W:0] t;
      begin
         t = x * $signed({1'b0, OMEGA});
         omega_half = t[2*W+`PEDP_OMEGA_SHIFT:`PEDP_OMEGA_SHIFT+1];
      end
   endfunction
   // Widens a signed power to the energy counter width.
   function signed [AW-1:0] sext;
      input signed [2*W-1:0] x;
      begin
         sext = {{(AW-2*W){x[2*W-1]}}, x};
      end
   endfunction
   // Even parity nibble over a 20-bit field.
   function [31:0] mk_rec;
      input [`PEDP_REC_W-1:0] d;
      reg [3:0] p;
      integer k;
      begin
         p = 4'h0;
         for (k = 0; k < `PEDP_REC_W; k = k + 4) begin
            p = p ^ d[k+:4];
         end
         mk_rec = {p, {(`PEDP_PAR_LSB-`PEDP_REC_W){1'b0}}, d};
      end
   endfunction

   // ****************************************
   // Differentiator and integrators.
   // ****************************************
   reg signed [W-1:0] v_prev_ff;
   reg signed [W-1:0] dv_ff;
   reg signed [W-1:0] vr_ff;
   reg signed [W-1:0] ii_ff;
   reg signed [W-1:0] i_d_ff;
   reg stg_vld_ff;
   wire signed [W-1:0] nxt_dv;
   assign nxt_dv = v_smp - v_prev_ff;
   always @(posedge clk or negedge rst_i_b) begin
      if (!rst_i_b) begin
         v_prev_ff <= {W{1'b0}};
         dv_ff <= {W{1'b0}};
         vr_ff <= {W{1'b0}};
         ii_ff <= {W{1'b0}};
         i_d_ff <= {W{1'b0}};
         stg_vld_ff <= 1'b0;
      end else begin
         stg_vld_ff <= smp_vld;
         if (smp_vld) begin
            v_prev_ff <= v_smp;
            dv_ff <= nxt_dv;
            vr_ff <= vr_ff + nxt_dv;
            ii_ff <= ii_ff + i_smp;
            i_d_ff <= i_smp;
         end
      end
   end

   // ****************************************
   // Multipliers and powers.
   // ****************************************
   wire signed [2*W-1:0] prod1;
   wire signed [2*W-1:0] prod2;
   wire signed [2*W-1:0] prodq;
   wire signed [2*W:0] pdiff;
   wire signed [W-1:0] ii_om;
   wire signed [2*W-1:0] ii_om_w;
   assign prod1 = dv_ff * ii_ff;
   assign prod2 = vr_ff * i_d_ff;
   assign pdiff = {prod2[2*W-1], prod2} - {prod1[2*W-1], prod1};
   assign prodq = vr_ff * ii_ff;
   assign ii_om_w = ii_ff * $signed({1'b0, OMEGA});
   assign ii_om = ii_om_w[W-1+`PEDP_OMEGA_SHIFT:`PEDP_OMEGA_SHIFT];
   wire [W-1:0] ii_rms;
   wire [W-1:0] dv_rms;
   wire [W-1:0] v_rms;
   wire ii_rms_vld;
   wire v_rms_vld;
   wire [W-1:0] i_rms_w;
   wire i_rms_vld;
   wire [2*W-1:0] app;
   assign app = ii_rms * dv_rms;
   // Current RMS via integrated current scaled by omega.
   pedp_msq #(.W(W), .LOG2N(LOG2N)) u_irms (
      .clk(clk),
      .rst_b(rst_i_b),
      .smp_vld(stg_vld_ff),
      .smp(ii_om),
      .rms_ff(i_rms_w),
      .rms_vld_ff(i_rms_vld)
   );
   pedp_msq #(.W(W), .LOG2N(LOG2N)) u_iirms (
      .clk(clk),
      .rst_b(rst_i_b),
      .smp_vld(stg_vld_ff),
      .smp(ii_ff),
      .rms_ff(ii_rms),
      .rms_vld_ff(ii_rms_vld)
   );
   pedp_msq #(.W(W), .LOG2N(LOG2N)) u_dvrms (
      .clk(clk),
      .rst_b(rst_i_b),
      .smp_vld(stg_vld_ff),
      .smp(dv_ff),
      .rms_ff(dv_rms),
      .rms_vld_ff()
   );
   pedp_msq #(.W(W), .LOG2N(LOG2N)) u_vrms (
      .clk(clk),
      .rst_b(rst_i_b),
      .smp_vld(stg_vld_ff),
      .smp(vr_ff),
      .rms_ff(v_rms),
      .rms_vld_ff(v_rms_vld)
   );

   // ****************************************
   // Power registers and energy counters.
   // ****************************************
   reg signed [AW-1:0] e_act_ff;
   reg signed [AW-1:0] e_react_ff;
   reg [AW-1:0] e_app_ff;
   always @(posedge clk or negedge rst_i_b) begin
      if (!rst_i_b) begin
         p_act_ff <= {(2*W){1'b0}};
         p_react_ff <= {(2*W){1'b0}};
         p_app_ff <= {(2*W){1'b0}};
         pwr_vld_ff <= 1'b0;
         v_rms_ff <= {W{1'b0}};
         i_rms_ff <= {W{1'b0}};
         e_act_ff <= {AW{1'b0}};
         e_react_ff <= {AW{1'b0}};
         e_app_ff <= {AW{1'b0}};
      end else begin
         pwr_vld_ff <= stg_vld_ff;
         if (v_rms_vld) begin
            v_rms_ff <= v_rms;
         end
         if (i_rms_vld) begin
            i_rms_ff <= i_rms_w;
         end
         if (ii_rms_vld) begin
            p_app_ff <= app;
         end
         if (stg_vld_ff) begin
            p_act_ff <= pdiff[2*W:1];
            p_react_ff <= omega_half(prodq);
            // Signed powers count up or down and wrap.
            e_act_ff <= e_act_ff + sext(pdiff[2*W:1]);
            e_react_ff <= e_react_ff + sext(omega_half(prodq));
            e_app_ff <= e_app_ff + {{(AW-2*W){1'b0}}, p_app_ff};
         end
      end
   end

   // ****************************************
   // Energy data records.
   // ****************************************
   always @(posedge clk or negedge rst_i_b) begin
      if (!rst_i_b) begin
         rec_act_ff <= 32'h00000000;
         rec_react_ff <= 32'h00000000;
         rec_app_ff <= 32'h00000000;
      end else begin
         // Reactive energy reaches only its record, nothing else.
         rec_act_ff <= mk_rec(e_act_ff[AW-1:AW-`PEDP_REC_W]);
         rec_react_ff <= mk_rec(e_react_ff[AW-1:AW-`PEDP_REC_W]);
         rec_app_ff <= mk_rec(e_app_ff[AW-1:AW-`PEDP_REC_W]);
      end
   end
endmodule
`default_nettype wire

//--- rtl/pedp_msq.v
// Mean square and square root over one accumulation period.
`timescale 1ns/1ps
`default_nettype none
module pedp_msq #(
   parameter W = 16,
   parameter LOG2N = 11
) (
   // Clock and reset.
   input wire clk,
   input wire rst_b,
   // Sample stream.
   input wire smp_vld,
   input wire signed [W-1:0] smp,
   // Result.
   output reg [W-1:0] rms_ff,
   output reg rms_vld_ff
);
   reg [2*W+LOG2N-1:0] sum_ff;
   reg [LOG2N-1:0] cnt_ff;
   wire [2*W-1:0] sq;
   wire [2*W-1:0] mean;
   wire [2*W+LOG2N-1:0] sum_nxt;
   assign sq = smp * smp;
   assign sum_nxt = sum_ff + {{LOG2N{1'b0}}, sq};
   assign mean = sum_nxt[2*W+LOG2N-1:LOG2N];
   // Integer square root, bitwise restoring.
   function [W-1:0] isqrt;
      input [2*W-1:0] x;
      reg [W-1:0] r;
      integer k;
      begin
         r = {W{1'b0}};
         for (k = W-1; k >= 0; k = k - 1) begin
            r[k] = 1'b1;
            if ({{W{1'b0}}, r} * {{W{1'b0}}, r} > {{W{1'b0}}, x}) begin
               r[k] = 1'b0;
            end
         end
         isqrt = r;
      end
   endfunction
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sum_ff <= {(2*W+LOG2N){1'b0}};
         cnt_ff <= {LOG2N{1'b0}};
         rms_ff <= {W{1'b0}};
         rms_vld_ff <= 1'b0;
      end else begin
         rms_vld_ff <= 1'b0;
         if (smp_vld) begin
            cnt_ff <= cnt_ff + 1'b1;
            if (&cnt_ff) begin
               rms_ff <= isqrt(mean);
               rms_vld_ff <= 1'b1;
               sum_ff <= {(2*W+LOG2N){1'b0}};
            end else begin
               sum_ff <= sum_nxt;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- test/pedp_dp_monitor.sv
// Checker for the power and energy datapath.
`timescale 1ns/1ps
`default_nettype none
module pedp_dp_monitor #(parameter W = 16) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Watched ports.
   input wire logic smp_vld,
   input wire logic pwr_vld_ff,
   input wire logic signed [2*W-1:0] p_act_ff,
   input wire logic signed [2*W-1:0] p_react_ff,
   input wire logic [31:0] rec_act_ff,
   input wire logic [31:0] rec_react_ff,
   input wire logic [31:0] rec_app_ff
);
   // *****
   // Checks
   // *****
   function automatic logic fmt_ok(input logic [31:0] r);
      fmt_ok = r[27:20] == 8'h00 && r[31:28] == (r[3:0] ^ r[7:4] ^ r[11:8] ^ r[15:12] ^ r[19:16]);
   endfunction
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_done;
      ##2 pwr_vld_ff;
   endsequence
   chk_vld_late: assert property (smp_vld |-> s_done) else $error("power valid late");
   chk_vld_cause: assert property (pwr_vld_ff |-> $past(smp_vld, 2)) else $error("stray valid");
   chk_act_hold: assert property (!pwr_vld_ff |-> $stable(p_act_ff)) else $error("active moved");
   chk_react_hold: assert property (!pwr_vld_ff |-> $stable(p_react_ff)) else $error("reactive moved");
   chk_rec_hold: assert property (!$past(smp_vld, 3) |-> $stable(rec_act_ff)) else $error("record moved");
   chk_act_fmt: assert property (fmt_ok(rec_act_ff)) else $error("active record format");
   chk_react_fmt: assert property (fmt_ok(rec_react_ff)) else $error("reactive record format");
   chk_app_fmt: assert property (fmt_ok(rec_app_ff)) else $error("apparent record format");
endmodule
bind pedp_datapath pedp_dp_monitor #(.W(W)) u_mon (.clk(clk), .rst_b(rst_b), .smp_vld(smp_vld),
   .pwr_vld_ff(pwr_vld_ff), .p_act_ff(p_act_ff), .p_react_ff(p_react_ff),
   .rec_act_ff(rec_act_ff), .rec_react_ff(rec_react_ff), .rec_app_ff(rec_app_ff));
`default_nettype wire

//--- test/pedp_src.sv
// Converter sample stream model: square waves of set amplitude.
`timescale 1ns/1ps
`default_nettype none
module pedp_src (
   // Clock and control.
   input wire logic clk,
   input wire logic run,
   input wire logic [15:0] amp_v,
   input wire logic [15:0] amp_i,
   // Sample streams.
   output logic smp_vld,
   output logic [15:0] v_smp,
   output logic [15:0] i_smp
);
   // *****
   // Stream
   // *****
   logic act;
   logic [2:0] ph = 3'h0;
   initial begin
      smp_vld = 1'b0;
      v_smp = 16'h0000;
      i_smp = 16'h0000;
   end
   // Idle lines carry no data, so they toggle instead of holding.
   always @(posedge clk) begin
      act = run;
      #1;
      ph = ph + 3'h1;
      smp_vld = act;
      v_smp = act ? (ph[2] ? -amp_v : amp_v) : ~v_smp;
      i_smp = act ? (ph[2] ? -amp_i : amp_i) : ~i_smp;
   end
endmodule
`default_nettype wire

//--- test/test_pedp_datapath.sv
// Self-checking bench for the power and energy datapath.
`timescale 1ns/1ps
`default_nettype none
module test_pedp_datapath;
   // *****
   // Bench
   // *****
   logic clk, rst_b, run;
   logic [15:0] amp_v, amp_i;
   wire smp_vld, pwr_vld;
   wire [15:0] v_smp, i_smp, v_rms, i_rms;
   wire [31:0] p_act, p_react, p_app, rec_act, rec_react, rec_app;
   int bad_count, checked;
   pedp_src u_src (.clk(clk), .run(run), .amp_v(amp_v), .amp_i(amp_i), .smp_vld(smp_vld),
      .v_smp(v_smp), .i_smp(i_smp));
   pedp_datapath #(.LOG2N(3)) u_dut (.clk(clk), .rst_b(rst_b), .smp_vld(smp_vld),
      .v_smp(v_smp), .i_smp(i_smp), .p_act_ff(p_act), .p_react_ff(p_react),
      .p_app_ff(p_app), .pwr_vld_ff(pwr_vld), .v_rms_ff(v_rms), .i_rms_ff(i_rms),
      .rec_act_ff(rec_act), .rec_react_ff(rec_react), .rec_app_ff(rec_app));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input logic ok, input string msg);
      checked = checked + 1;
      if (ok !== 1'b1) begin
         bad_count = bad_count + 1;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic play(input int n);
      run = 1'b1;
      repeat (n) @(posedge clk) #1;
      run = 1'b0;
      repeat (5) @(posedge clk) #1;
   endtask
   task automatic t_reset;
      rst_b = 1'b0;
      repeat (4) @(posedge clk) #1;
      rst_b = 1'b1;
      repeat (3) @(posedge clk) #1;
      check({p_act, p_react, p_app, pwr_vld, v_rms, i_rms, rec_act, rec_react, rec_app} === '0,
         "outputs not clear");
      $display("reset test done");
   endtask
   task automatic t_latency;
      int n;
      n = 0;
      run = 1'b1;
      @(posedge clk) #1 run = 1'b0;
      while (pwr_vld !== 1'b1 && n < 9) begin
         @(posedge clk) #1;
         n = n + 1;
      end
      check(n == 2, "power latency");
      if (n == 9) give_verdict;
      @(posedge clk) #1;
      check(pwr_vld === 1'b0, "power valid longer than one cycle");
      $display("latency test done");
   endtask
   task automatic t_volt;
      amp_v = 16'h0400;
      amp_i = 16'h0000;
      play(32);
      check(p_act === 32'h0 && p_react === 32'h0, "power without current");
      check(i_rms === 16'h0 && p_app === 32'h0, "rms without current");
      check(v_rms === amp_v, "voltage rms");
      $display("voltage test done");
   endtask
   task automatic t_both;
      amp_i = 16'h0010;
      play(32);
      check(v_rms === amp_v, "voltage rms with load");
      check(i_rms !== 16'h0 && ^i_rms !== 1'bx, "current rms");
      check(p_app !== 32'h0 && ^p_app !== 1'bx, "apparent power");
      check(i_rms >= 16'h0010 && i_rms <= 16'h0040, "current rms range");
      check(p_app === {16'h0000, i_rms} * {16'h0000, amp_v}, "apparent product");
      check(rec_act[19:0] >= 20'h00050 && rec_act[19:0] <= 20'h00070,
         "active energy");
      check(rec_react[19:0] >= 20'h0001c && rec_react[19:0] <= 20'h00024,
         "reactive energy");
      $display("load test done");
   endtask
   task automatic t_anti;
      amp_i = 16'hfff0;
      play(64);
      check(v_rms === amp_v, "voltage rms with reversed load");
      check(p_app === {16'h0000, i_rms} * {16'h0000, amp_v}, "apparent reversed");
      check(rec_act[19:0] >= 20'hfff70 && rec_act[19:0] <= 20'hfffd0,
         "active energy did not count down through zero");
      $display("reverse load test done");
   endtask
   initial begin
      rst_b = 1'b0;
      run = 1'b0;
      amp_v = 16'h0000;
      amp_i = 16'h0000;
      bad_count = 0;
      checked = 0;
      t_reset();
      t_latency();
      t_volt();
      t_both();
      t_anti();
      t_reset();
      give_verdict();
   end
endmodule
`default_nettype wire
